//--- src/serial_command_port.sv
// Notes on behaviour
// - Strap absent gives 115k baud, strap installed gives 19.2k baud.
// - Frames are one start, eight data, no parity, one stop, full duplex.
// - Received characters are held in a four-byte FIFO.
// - CTS high while reset is asserted or the FIFO holds three or more characters, low otherwise.
// - Host holds RTS high to inhibit; no new character starts then.
// - Port acts as the data-set end of the link.
// - A lone carriage return is answered with a colon prompt.
`timescale 1ns/1ps
module serial_command_port
    import serial_port_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = RX_FIFO_DEPTH,
    parameter int unsigned TX_BUF_DEPTH = 2
)(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic baud_strap,
    input wire logic rxd,
    input wire logic rts,
    output logic txd,
    output logic cts,
    output logic dce_role,
    output byte_beat_t rx_out,
    input wire logic rx_ready,
    input wire byte_beat_t tx_in,
    output logic tx_ready
);

    // Pointer and index widths below only serve these depths
    if (FIFO_DEPTH != 4 || TX_BUF_DEPTH != 2)
    begin
        $error("serial_command_port: depths must be 4 and 2");
    end

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;

    typedef struct packed {
        logic slow;
        logic [15:0] rx_cnt;
        rx_state_t rx_st;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic [3:0][7:0] fifo;
        logic [1:0] f_rd;
        logic [2:0] f_cnt;
        byte_beat_t out;
        logic prev_cr_free;
        logic prompt;
        logic [1:0][7:0] tbuf;
        logic t_rd;
        logic [1:0] t_cnt;
        logic [15:0] tx_cnt;
        tx_state_t tx_st;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic txd;
        logic cts;
        logic tx_ready;
        logic role;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic [15:0] div_full;
    logic [15:0] div_half;
    logic [7:0] rx_byte;
    logic push;
    logic pop;
    logic tpush;
    logic tpop;
    logic [1:0] wr_idx;
    logic prompt_set;

    always_comb
    begin
        s_nxt = s_r;
        div_full = s_r.slow ? 16'(DIV_SLOW) : 16'(DIV_FAST);
        div_half = {1'b0, div_full[15:1]};
        rx_byte = {rxd, s_r.rx_sh[7:1]};
        push = 1'b0;
        pop = 1'b0;
        tpush = 1'b0;
        tpop = 1'b0;
        wr_idx = 2'(s_r.f_rd + s_r.f_cnt[1:0]);
        prompt_set = 1'b0;
        s_nxt.slow = baud_strap;
        s_nxt.role = 1'b1;

        // Receiver
        if (s_r.rx_cnt != 16'h0000)
            s_nxt.rx_cnt = 16'(s_r.rx_cnt - 16'h0001);
        case (s_r.rx_st)
            RX_IDLE:
            begin
                if (rxd != LINE_MARK)
                begin
                    s_nxt.rx_st = RX_START;
                    s_nxt.rx_cnt = div_half;
                end
            end
            RX_START:
            begin
                if (s_r.rx_cnt == 16'h0000)
                begin
                    if (rxd != LINE_MARK)
                    begin
                        s_nxt.rx_st = RX_DATA;
                        s_nxt.rx_bit = 3'h0;
                        s_nxt.rx_cnt = div_full;
                    end
                    else
                        s_nxt.rx_st = RX_IDLE;
                end
            end
            RX_DATA:
            begin
                if (s_r.rx_cnt == 16'h0000)
                begin
                    s_nxt.rx_sh = rx_byte;
                    s_nxt.rx_cnt = div_full;
                    s_nxt.rx_bit = 3'(s_r.rx_bit + 3'h1);
                    if (s_r.rx_bit == 3'(DATA_BITS - 1))
                        s_nxt.rx_st = RX_STOP;
                end
            end
            RX_STOP:
            begin
                if (s_r.rx_cnt == 16'h0000)
                begin
                    s_nxt.rx_st = RX_IDLE;
                    // Framing error drops the character
                    if (rxd == LINE_MARK && s_r.f_cnt != 3'(FIFO_DEPTH))
                    begin
                        push = 1'b1;
                        s_nxt.fifo[wr_idx] = s_r.rx_sh;
                        if (s_r.rx_sh == CHAR_CR && s_r.prev_cr_free)
                        begin
                            prompt_set = 1'b1;
                            s_nxt.prompt = 1'b1;
                        end
                        s_nxt.prev_cr_free = (s_r.rx_sh == CHAR_CR) || (s_r.rx_sh == 8'h0A);
                    end
                end
            end
            default:
                s_nxt.rx_st = RX_IDLE;
        endcase

        // Output stage of the receive FIFO
        if (s_r.out.valid && rx_ready)
            s_nxt.out.valid = 1'b0;
        if ((!s_r.out.valid || rx_ready) && s_r.f_cnt != 3'h0)
        begin
            pop = 1'b1;
            s_nxt.out.valid = 1'b1;
            s_nxt.out.data = s_r.fifo[s_r.f_rd];
            s_nxt.f_rd = 2'(s_r.f_rd + 2'h1);
        end
        s_nxt.f_cnt = 3'(s_r.f_cnt + {2'b00, push} - {2'b00, pop});
        // Not ready once the store is full or one more would fill it
        s_nxt.cts = (s_nxt.f_cnt >= 3'(FIFO_DEPTH - 1));

        // Two-entry transmit buffer
        if (tx_in.valid && s_r.tx_ready)
        begin
            tpush = 1'b1;
            s_nxt.tbuf[1'(s_r.t_rd + s_r.t_cnt[0])] = tx_in.data;
        end

        // Transmitter
        if (s_r.tx_cnt != 16'h0000)
            s_nxt.tx_cnt = 16'(s_r.tx_cnt - 16'h0001);
        case (s_r.tx_st)
            TX_IDLE:
            begin
                s_nxt.txd = LINE_MARK;
                if (!rts)
                begin
                    if (s_r.prompt)
                    begin
                        // A prompt requested in this same cycle survives
                        s_nxt.prompt = prompt_set;
                        s_nxt.tx_sh = CHAR_COLON;
                        s_nxt.tx_st = TX_START;
                    end
                    else if (s_r.t_cnt != 2'h0)
                    begin
                        tpop = 1'b1;
                        s_nxt.tx_sh = s_r.tbuf[s_r.t_rd];
                        s_nxt.t_rd = ~s_r.t_rd;
                        s_nxt.tx_st = TX_START;
                    end
                    if (s_r.prompt || s_r.t_cnt != 2'h0)
                    begin
                        s_nxt.txd = ~LINE_MARK;
                        s_nxt.tx_cnt = div_full;
                    end
                end
            end
            TX_START:
            begin
                if (s_r.tx_cnt == 16'h0000)
                begin
                    s_nxt.tx_st = TX_DATA;
                    s_nxt.tx_bit = 3'h0;
                    s_nxt.txd = s_r.tx_sh[0];
                    s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
                    s_nxt.tx_cnt = div_full;
                end
            end
            TX_DATA:
            begin
                if (s_r.tx_cnt == 16'h0000)
                begin
                    s_nxt.tx_cnt = div_full;
                    s_nxt.tx_bit = 3'(s_r.tx_bit + 3'h1);
                    if (s_r.tx_bit == 3'(DATA_BITS - 1))
                    begin
                        s_nxt.tx_st = TX_STOP;
                        s_nxt.txd = LINE_MARK;
                    end
                    else
                    begin
                        s_nxt.txd = s_r.tx_sh[0];
                        s_nxt.tx_sh = {1'b0, s_r.tx_sh[7:1]};
                    end
                end
            end
            TX_STOP:
            begin
                if (s_r.tx_cnt == 16'h0000)
                    s_nxt.tx_st = TX_IDLE;
            end
            default:
                s_nxt.tx_st = TX_IDLE;
        endcase
        s_nxt.t_cnt = 2'(s_r.t_cnt + {1'b0, tpush} - {1'b0, tpop});
        s_nxt.tx_ready = (s_nxt.t_cnt != 2'(TX_BUF_DEPTH));
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            s_r <= '0;
            s_r.rx_st <= RX_IDLE;
            s_r.tx_st <= TX_IDLE;
            s_r.txd <= LINE_MARK;
            s_r.prev_cr_free <= 1'b1;
            s_r.cts <= 1'b1;
            s_r.role <= 1'b1;
            s_r.rx_cnt <= DIV_RESET;
            s_r.tx_cnt <= DIV_RESET;
        end
        else
            s_r <= s_nxt;
    end

    assign txd = s_r.txd;
    assign cts = s_r.cts;
    assign rx_out = s_r.out;
    assign tx_ready = s_r.tx_ready;
    assign dce_role = s_r.role;

endmodule

//--- src/serial_port_pkg.sv
package serial_port_pkg;

    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned BAUD_FAST = 115_200;
    localparam int unsigned BAUD_SLOW = 19_200;
    localparam int unsigned DIV_FAST = CLK_HZ / BAUD_FAST;
    localparam int unsigned DIV_SLOW = CLK_HZ / BAUD_SLOW;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned RX_FIFO_DEPTH = 4;
    localparam logic [7:0] CHAR_CR = 8'h0D;
    localparam logic [7:0] CHAR_COLON = 8'h3A;
    localparam logic LINE_MARK = 1'b1;
    localparam logic [15:0] DIV_RESET = 16'h0000;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;

endpackage

//--- verif/host_terminal.sv
`timescale 1ns/1ps
module host_terminal
    import serial_port_pkg::*;
(
    input wire logic sys_clk,
    input wire logic baud_strap,
    input wire logic txd,
    input wire logic cts,
    output logic rxd,
    output logic rts
);
    logic [7:0] got_q[$];
    logic [7:0] d;
    int bit_len;
    assign bit_len = baud_strap ? DIV_SLOW + 1 : DIV_FAST + 1;
    initial
    begin
        rxd = LINE_MARK;
        rts = 1'b0;
    end
    task automatic send(input logic [7:0] b);
        while (cts !== 1'b0)
            @(negedge sys_clk);
        for (int i = 0; i < 10; i++)
        begin
            rxd = (i == 0) ? 1'b0 : (i == 9) ? LINE_MARK : b[i - 1];
            repeat (bit_len) @(negedge sys_clk);
        end
    endtask
    // Receiver samples each of the eight data bits in its middle; start and stop bits are not sampled
    always
    begin
        @(negedge txd);
        repeat (bit_len * 3 / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++)
        begin
            d[i] = txd;
            repeat (bit_len) @(posedge sys_clk);
        end
        got_q.push_back(d);
    end
endmodule

//--- verif/serial_port_asserts.sv
`timescale 1ns/1ps
module serial_port_asserts
    import serial_port_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic baud_strap,
    input wire logic rts,
    input wire logic txd,
    input wire logic cts,
    input wire logic dce_role,
    input wire byte_beat_t rx_out,
    input wire logic rx_ready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    int bit_len;
    int fc_r;
    logic pop;
    assign bit_len = baud_strap ? DIV_SLOW + 1 : DIV_FAST + 1;
    assign pop = rx_out.valid && rx_ready;
    // Cycles left until the middle of the stop bit on txd
    always_ff @(posedge sys_clk or posedge reset)
        if (reset)
            fc_r <= 0;
        else if (fc_r != 0)
            fc_r <= fc_r - 1;
        else if ($fell(txd))
            fc_r <= 9 * bit_len + bit_len / 2;
    a_role_fixed: assert property (dce_role) else $error("role low");
    a_cts_reset: assert property ($fell(reset) |-> ##1 !cts[*2]) else $error("cts not low");
    a_cts_rise: assert property ($rose(cts) |-> rx_out.valid) else $error("cts rose empty");
    a_cts_fall: assert property ($fell(cts) |-> $past(pop) || $past(pop, 2) || $past(pop, 3) || $past(reset, 2))
        else $error("cts fell no pop");
    a_rx_hold: assert property (rx_out.valid && !rx_ready |=> rx_out.valid && $stable(rx_out.data))
        else $error("rx byte lost");
    a_rts_block: assert property ($fell(txd) && fc_r == 0 |-> !$past(rts))
        else $error("start under rts");
    a_start_low: assert property (fc_r == 9 * bit_len |-> !txd) else $error("start bit");
    a_stop_mark: assert property (fc_r == 1 |-> txd) else $error("stop bit");
    cover property ($rose(cts));
    cover property (fc_r == 1);
    cover property (pop);
endmodule

bind serial_command_port serial_port_asserts u_chk (.sys_clk, .reset, .baud_strap, .rts, .txd, .cts, .dce_role,
    .rx_out, .rx_ready);

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
    import serial_port_pkg::*;
    logic sys_clk = 0;
    logic reset = 1;
    logic baud_strap = 0;
    logic rx_ready = 0;
    logic rxd, rts, txd, cts, dce_role, tx_ready;
    byte_beat_t rx_out;
    byte_beat_t tx_in = '0;
    int num_errors = 0;
    int num_checks = 0;
    int n;
    // Four bytes fill the store to its cts level; the last CR follows text
    logic [15:0] rows [4] = '{16'h0d0d, 16'h4141, 16'ha5a5, 16'h0d0d};
    always #2 sys_clk = ~sys_clk;
    serial_command_port dut (.sys_clk, .reset, .baud_strap, .rxd, .rts, .txd, .cts, .dce_role, .rx_out,
        .rx_ready, .tx_in, .tx_ready);
    host_terminal host (.sys_clk, .baud_strap, .txd, .cts, .rxd, .rts);
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(negedge sys_clk);
        check("txd", 1'b1, txd);
        check("cts", 1'b1, cts);
        reset = 0;
        repeat (2) @(negedge sys_clk);
        check("role", 1'b1, dce_role);
        check("cts", 1'b0, cts);
        check("tx_ready", 1'b1, tx_ready);
        host.rts = 1;
        tx_in = '{1'b1, 8'h5a};
        @(negedge sys_clk);
        tx_in.valid = 0;
        foreach (rows[i])
        begin
            host.send(rows[i][15:8]);
            if (i == 0)
            begin
                check("sent", 16'h0000, 16'(host.got_q.size()));
                host.rts = 0;
            end
        end
        repeat (20) @(negedge sys_clk);
        check("cts", 1'b1, cts);
        foreach (rows[i])
        begin
            for (n = 0; n < 100 && rx_out.valid !== 1'b1; n++)
                @(negedge sys_clk);
            check("rx", rows[i][7:0], rx_out.data);
            rx_ready = 1;
            @(negedge sys_clk);
            rx_ready = 0;
        end
        repeat (20) @(negedge sys_clk);
        check("cts", 1'b0, cts);
        repeat (20) @(negedge sys_clk);
        check("replies", 16'h0002, 16'(host.got_q.size()));
        check("prompt", CHAR_COLON, host.got_q[0]);
        check("byte", 8'h5a, host.got_q[1]);
        baud_strap = 1;
        tx_in = '{1'b1, 8'h01};
        @(negedge sys_clk);
        tx_in.valid = 0;
        for (n = 0; n < 20000 && txd; n++)
            @(negedge sys_clk);
        for (n = 0; n < 20000 && !txd; n++)
            @(negedge sys_clk);
        check("start", 16'(DIV_SLOW + 1), 16'(n));
        conclude();
    end
    initial
    begin
        repeat (110000) @(posedge sys_clk);
        num_errors++;
        conclude();
    end
endmodule
